// ### src/pbm_map.vh
// register offsets, reset values and field positions of the port b pin mux
`ifndef PBM_MAP_VH
`define PBM_MAP_VH
`define PBM_ADDR_W 3
`define PBM_OFS_OUT 3'h0
`define PBM_OFS_IN 3'h1
`define PBM_OFS_DIR 3'h2
`define PBM_OFS_OPEN 3'h3
`define PBM_OFS_PULL 3'h4
`define PBM_OFS_ANA 3'h5
`define PBM_OFS_FUNC 3'h6
`define PBM_RST_BYTE 8'h00
`define PBM_RST_PAIR 4'h0
`define PBM_RST_FUNC 7'h00
`define PBM_RST_SEL 16'h0000
`define PBM_ANA_PAD 4'h0
`define PBM_FN_PWM0 0
`define PBM_FN_PWM1 1
`define PBM_FN_XTAL 2
`define PBM_FN_CPU 3
`define PBM_FN_SYNC 4
`define PBM_FN_TX 5
`define PBM_FN_RX 6
`define PBM_PIN_PWM0 0
`define PBM_PIN_PWM1 1
`define PBM_PIN_CPU 2
`define PBM_PIN_XTAL 3
`define PBM_PIN_S0 4
`define PBM_PIN_S1 5
`define PBM_PIN_TX 6
`define PBM_PIN_RX 7
`endif

// ### src/pbm_port_b_pin_function_mux.v
// port b pin function mux: analog, peripheral and digital ownership of eight pads
//
// Contract
// - analog pair mode overrides peripheral functions and digital setup on both pins.
// - outside analog mode an enabled sync, tx or rx function overrides digital setup; pwm, cpu and crystal clocks replace only the output value.
// - no analog, no function: plain digital pin; default after reset.
// - pair analog select bit at one puts its pin pair in analog mode.
// - select bits 0..3 map pairs 1:0..7:6; upper four bits read zero.
// - analog mode: connect bit one closes switch, zero leaves pin floating.
// - odd pin line choice from output value bits x and x-1.
// - even pin line choice from direction bits x+1 and x.
// - enabled pwm outputs replace output value on pins 0 and 1.
// - crystal clock on pin 3 when enabled and oscillator runs; direction kept.
// - cpu clock replaces output value on pin 2; direction kept.
// - sync serial enabled makes pins 5,4 open-drain, ignoring port settings except pull-up.
// - serial lines as outputs drive pins 4 and 5 from their values.
// - async tx enable drives pin 6 as transmit output.
// - async rx enable makes pin 7 the receive input.
// - digital direction one enables output buffer, zero leaves output floating.
// - input buffer active in every mode except analog.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pbm_map.vh"
module pbm_port_b_pin_function_mux (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // register port
  input wire [`PBM_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // peripheral side
  input wire pwm0_level_i,
  input wire pwm1_level_i,
  input wire crystal_clock_i,
  input wire crystal_osc_enable_i,
  input wire cpu_clock_i,
  input wire sync_line0_value_i,
  input wire sync_line1_value_i,
  input wire sync_line0_is_output_i,
  input wire sync_line1_is_output_i,
  input wire async_tx_i,
  output reg async_rx_o,
  output reg [1:0] sync_line_in_o,
  // pads
  input wire [7:0] pad_in_i,
  output reg [7:0] pad_out_o,
  output reg [7:0] pad_oe_o,
  output reg [7:0] pad_pullup_o,
  output reg [7:0] pad_in_enable_o,
  // analog switch matrix
  output reg [7:0] ana_connect_o,
  output reg [15:0] ana_line_sel_o
);

  reg [7:0] output_value_control;
  reg [7:0] direction_control;
  reg [7:0] open_drain_select;
  reg [7:0] pullup_connect_control;
  reg [3:0] analog_pair_control;
  reg [6:0] function_enable;
  reg [7:0] pad_meta;
  reg [7:0] pad_sync;
  reg xtal_meta;
  reg xtal_sync;

  reg [7:0] next_out;
  reg [7:0] next_val;
  reg [7:0] next_oe;
  reg [7:0] next_pull;
  reg [7:0] next_ie;
  reg [7:0] next_conn;
  reg [15:0] next_sel;
  reg [7:0] next_rdata;
  reg [7:0] fn_owned;
  wire [7:0] ana_pin;
  integer i;

  // pair index is the same for both pins: x,x-1 when odd, x+1,x when even
  function [1:0] pbm_line;
    input [2:0] pin;
    input [7:0] ov;
    input [7:0] dv;
    begin
      if (pin[0])
        pbm_line = {ov[{pin[2:1], 1'b1}], ov[{pin[2:1], 1'b0}]};
      else
        pbm_line = {dv[{pin[2:1], 1'b1}], dv[{pin[2:1], 1'b0}]};
    end
  endfunction

  // open drain: pulls low only, floats while the level is one
  function pbm_od;
    input drive;
    input level;
    begin
      pbm_od = drive & ~level;
    end
  endfunction

  assign ana_pin = {{2{analog_pair_control[3]}}, {2{analog_pair_control[2]}},
                    {2{analog_pair_control[1]}}, {2{analog_pair_control[0]}}};

  // pad synchroniser
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pad_meta <= `PBM_RST_BYTE;
      pad_sync <= `PBM_RST_BYTE;
    end
    else
    begin
      pad_meta <= pad_in_i;
      pad_sync <= pad_meta;
    end
  end

  // crystal clock is its own domain: two flops, slow clocks only
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
    end
    else
    begin
      xtal_meta <= crystal_clock_i;
      xtal_sync <= xtal_meta;
    end
  end

  // register writes
  // reset state is plain digital input
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      output_value_control <= `PBM_RST_BYTE;
      direction_control <= `PBM_RST_BYTE;
      open_drain_select <= `PBM_RST_BYTE;
      pullup_connect_control <= `PBM_RST_BYTE;
      analog_pair_control <= `PBM_RST_PAIR;
      function_enable <= `PBM_RST_FUNC;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `PBM_OFS_OUT: output_value_control <= reg_wdata_i;
        `PBM_OFS_DIR: direction_control <= reg_wdata_i;
        `PBM_OFS_OPEN: open_drain_select <= reg_wdata_i;
        `PBM_OFS_PULL: pullup_connect_control <= reg_wdata_i;
        `PBM_OFS_ANA: analog_pair_control <= reg_wdata_i[3:0];
        `PBM_OFS_FUNC: function_enable <= reg_wdata_i[6:0];
        default: ;
      endcase
    end
  end

  // read mux
  always @*
  begin
    next_rdata = `PBM_RST_BYTE;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PBM_OFS_OUT: next_rdata = output_value_control;
        // analog pins read zero
        `PBM_OFS_IN: next_rdata = pad_sync & ~ana_pin;
        `PBM_OFS_DIR: next_rdata = direction_control;
        `PBM_OFS_OPEN: next_rdata = open_drain_select;
        `PBM_OFS_PULL: next_rdata = pullup_connect_control;
        `PBM_OFS_ANA: next_rdata = {`PBM_ANA_PAD, analog_pair_control};
        `PBM_OFS_FUNC: next_rdata = {1'b0, function_enable};
        default: next_rdata = `PBM_RST_BYTE;
      endcase
    end
  end

  // per-pin ownership
  // combinational selection
  always @*
  begin
    next_out = `PBM_RST_BYTE;
    next_oe = `PBM_RST_BYTE;
    next_pull = `PBM_RST_BYTE;
    next_ie = `PBM_RST_BYTE;
    next_conn = `PBM_RST_BYTE;
    next_sel = `PBM_RST_SEL;
    fn_owned = `PBM_RST_BYTE;
    next_val = output_value_control;
    if (function_enable[`PBM_FN_PWM0])
      next_val[`PBM_PIN_PWM0] = pwm0_level_i;
    if (function_enable[`PBM_FN_PWM1])
      next_val[`PBM_PIN_PWM1] = pwm1_level_i;
    if (function_enable[`PBM_FN_CPU])
      next_val[`PBM_PIN_CPU] = cpu_clock_i;
    if (function_enable[`PBM_FN_XTAL] && crystal_osc_enable_i)
      next_val[`PBM_PIN_XTAL] = xtal_sync;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (open_drain_select[i])
      begin
        next_out[i] = 1'b0;
        next_oe[i] = pbm_od(direction_control[i], next_val[i]);
      end
      else
      begin
        next_out[i] = next_val[i];
        next_oe[i] = direction_control[i];
      end
      next_ie[i] = 1'b1;
    end
    // serial line values drive low only
    if (function_enable[`PBM_FN_SYNC])
    begin
      next_out[`PBM_PIN_S0] = 1'b0;
      next_out[`PBM_PIN_S1] = 1'b0;
      next_oe[`PBM_PIN_S0] = pbm_od(sync_line0_is_output_i, sync_line0_value_i);
      next_oe[`PBM_PIN_S1] = pbm_od(sync_line1_is_output_i, sync_line1_value_i);
      fn_owned[`PBM_PIN_S0] = 1'b1;
      fn_owned[`PBM_PIN_S1] = 1'b1;
    end
    if (function_enable[`PBM_FN_TX])
    begin
      next_out[`PBM_PIN_TX] = async_tx_i;
      next_oe[`PBM_PIN_TX] = 1'b1;
    end
    if (function_enable[`PBM_FN_RX])
    begin
      next_out[`PBM_PIN_RX] = 1'b0;
      next_oe[`PBM_PIN_RX] = 1'b0;
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      // pull-up only when floating high or input
      next_pull[i] = pullup_connect_control[i] & ~next_oe[i];
      if (fn_owned[i])
        next_pull[i] = pullup_connect_control[i] & ~next_oe[i];
      if (ana_pin[i])
      begin
        next_out[i] = 1'b0;
        next_oe[i] = 1'b0;
        next_pull[i] = 1'b0;
        next_ie[i] = 1'b0;
        next_conn[i] = pullup_connect_control[i];
        next_sel[2*i +: 2] = pbm_line(i[2:0], output_value_control, direction_control);
      end
    end
  end

  // registered outputs
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= `PBM_RST_BYTE;
      pad_out_o <= `PBM_RST_BYTE;
      pad_oe_o <= `PBM_RST_BYTE;
      pad_pullup_o <= `PBM_RST_BYTE;
      pad_in_enable_o <= `PBM_RST_BYTE;
      ana_connect_o <= `PBM_RST_BYTE;
      ana_line_sel_o <= `PBM_RST_SEL;
      async_rx_o <= 1'b1;
      sync_line_in_o <= 2'b11;
    end
    else
    begin
      reg_rdata_o <= next_rdata;
      pad_out_o <= next_out;
      pad_oe_o <= next_oe;
      pad_pullup_o <= next_pull;
      pad_in_enable_o <= next_ie;
      ana_connect_o <= next_conn;
      ana_line_sel_o <= next_sel;
      async_rx_o <= pad_sync[`PBM_PIN_RX] | ana_pin[`PBM_PIN_RX];
      sync_line_in_o <= {pad_sync[`PBM_PIN_S1], pad_sync[`PBM_PIN_S0]} | ana_pin[`PBM_PIN_S1:`PBM_PIN_S0];
    end
  end

endmodule // pbm_port_b_pin_function_mux

// ### test/pbm_pad_model.sv
// pad-side model: the level each pin reads back
`timescale 1ns/1ps
module pbm_pad_model (
  // pad side of the mux
  input wire clk_i,
  input wire [7:0] out_i,
  input wire [7:0] oe_i,
  input wire [7:0] pull_i,
  output wire [7:0] pad_o
);
  // floating pins wander so no stale level passes
  reg [7:0] wander = 8'h55;
  always @(posedge clk_i) wander <= ~wander;
  assign pad_o = (oe_i & out_i) | (~oe_i & pull_i) | (~oe_i & ~pull_i & wander);
endmodule // pbm_pad_model

// ### test/pbm_port_b_pin_function_mux_properties.sv
// assertions on the port b pin mux ports
`timescale 1ns/1ps
`include "pbm_map.vh"
module pbm_mux_properties (
  input wire ref_clk_i, rst_b_i, reg_wr_i, reg_rd_i, pwm0_level_i, async_tx_i,
  input wire sync_line0_value_i, sync_line0_is_output_i,
  input wire [`PBM_ADDR_W-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i, reg_rdata_o, pad_out_o, pad_oe_o, pad_pullup_o, pad_in_enable_o, ana_connect_o,
  input wire [15:0] ana_line_sel_o
);
  reg [7:0] sh_out, sh_dir, sh_open, sh_pull, sh_fn;
  reg [3:0] sh_ana;
  reg [1:0] up;
  wire [7:0] am = {{2{sh_ana[3]}}, {2{sh_ana[2]}}, {2{sh_ana[1]}}, {2{sh_ana[0]}}};
  wire ok = up[1];
  // shadows of the written registers
  always @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      {sh_out, sh_dir, sh_open, sh_pull, sh_fn, sh_ana, up} <= 46'h0;
    else
    begin
      up <= up + {1'b0, ~up[1]};
      if (reg_wr_i && reg_addr_i == `PBM_OFS_OUT) sh_out <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `PBM_OFS_DIR) sh_dir <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `PBM_OFS_OPEN) sh_open <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `PBM_OFS_PULL) sh_pull <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `PBM_OFS_ANA) sh_ana <= reg_wdata_i[3:0];
      if (reg_wr_i && reg_addr_i == `PBM_OFS_FUNC) sh_fn <= reg_wdata_i & 8'h7f;
    end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_rd_ana;
    reg_rd_i && reg_addr_i == `PBM_OFS_ANA;
  endsequence
  AST_ANA_QUIET: assert property (ok |-> ((pad_oe_o | pad_pullup_o | pad_out_o) & $past(am)) == 8'h00)
    else $error("analog pin still driven");
  AST_IN_ENABLE: assert property (ok |-> pad_in_enable_o == ~$past(am))
    else $error("input buffer enable wrong");
  AST_CONNECT: assert property (ok |-> ana_connect_o == $past(sh_pull & am))
    else $error("analog switch wrong");
  AST_LINE_SEL: assert property (ok && $past(sh_ana[1]) |->
    ana_line_sel_o[7:4] == $past({sh_out[3:2], sh_dir[3:2]}))
    else $error("analog line choice wrong");
  AST_DIGITAL: assert property (ok && $past(sh_fn == 8'h00 && sh_open == 8'h00) |->
    pad_oe_o == $past(sh_dir & ~am) && pad_out_o == $past(sh_out & ~am))
    else $error("digital pin wrong");
  AST_PWM0: assert property (ok && $past(sh_fn[0] && !sh_ana[0] && !sh_open[0]) |->
    pad_out_o[0] == $past(pwm0_level_i) && pad_oe_o[0] == $past(sh_dir[0]))
    else $error("pwm pin wrong");
  AST_TX: assert property (ok && $past(sh_fn[5] && !sh_ana[3]) |->
    pad_oe_o[6] && pad_out_o[6] == $past(async_tx_i))
    else $error("transmit pin wrong");
  AST_RX: assert property (ok && $past(sh_fn[6] && !sh_ana[3]) |-> !pad_oe_o[7])
    else $error("receive pin driven");
  AST_SYNC: assert property (ok && $past(sh_fn[4] && !sh_ana[2]) |->
    !pad_out_o[4] && pad_oe_o[4] == $past(sync_line0_is_output_i && !sync_line0_value_i))
    else $error("serial pin not open drain");
  AST_ANA_UPPER: assert property (s_rd_ana |=> reg_rdata_o[7:4] == 4'h0)
    else $error("analog control upper bits set");
endmodule // pbm_mux_properties
bind pbm_port_b_pin_function_mux pbm_mux_properties u_props (.*);

// ### test/pbm_port_b_pin_function_mux_tb.sv
// self-checking bench of the port b pin mux
`timescale 1ns/1ps
`include "pbm_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module port_b_pin_function_mux_tb;
  reg ref_clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  reg [2:0] reg_addr_i = 3'h0;
  reg [7:0] reg_wdata_i = 8'h00;
  reg pwm0 = 0, pwm1 = 0, xck = 0, xen = 0, cck = 0, s0v = 0, s1v = 0, s0o = 0, s1o = 0, tx = 0;
  wire async_rx_o;
  wire [1:0] sync_line_in_o;
  wire [7:0] reg_rdata_o, pad_in, pad_out_o, pad_oe_o, pad_pullup_o, pad_in_enable_o, ana_connect_o;
  wire [15:0] ana_line_sel_o;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  pbm_port_b_pin_function_mux uut (.ref_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .pwm0_level_i(pwm0), .pwm1_level_i(pwm1), .crystal_clock_i(xck), .crystal_osc_enable_i(xen),
    .cpu_clock_i(cck), .sync_line0_value_i(s0v), .sync_line1_value_i(s1v), .sync_line0_is_output_i(s0o),
    .sync_line1_is_output_i(s1o), .async_tx_i(tx), .async_rx_o, .sync_line_in_o, .pad_in_i(pad_in),
    .pad_out_o, .pad_oe_o, .pad_pullup_o, .pad_in_enable_o, .ana_connect_o, .ana_line_sel_o);
  pbm_pad_model pads (.clk_i(ref_clk_i), .out_i(pad_out_o), .oe_i(pad_oe_o), .pull_i(pad_pullup_o), .pad_o(pad_in));
  task wr(input [2:0] a, input [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 0;
  endtask
  task rd(input [2:0] a, input [7:0] e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 0;
    #1 `CHK(reg_rdata_o, e)
  endtask
  task w(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      end_sim;
    end
  end
  initial
  begin
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1;
    for (int a = 0; a < 8; a++) if (a != 1) rd(a[2:0], 8'h00);
    `CHK(pad_in_enable_o, 8'hff)
    $display("test reset done");
    wr(`PBM_OFS_DIR, 8'hff);
    wr(`PBM_OFS_OUT, 8'ha5);
    w(2);
    `CHK({pad_oe_o, pad_out_o}, 16'hffa5)
    w(3);
    rd(`PBM_OFS_IN, 8'ha5);
    `CHK({async_rx_o, sync_line_in_o}, 3'b110)
    wr(`PBM_OFS_OPEN, 8'h0f);
    wr(`PBM_OFS_PULL, 8'hff);
    w(2);
    `CHK({pad_oe_o, pad_pullup_o}, 16'hfa05)
    wr(`PBM_OFS_OPEN, 8'h00);
    wr(`PBM_OFS_PULL, 8'h00);
    $display("test digital done");
    {pwm0, pwm1, cck, xck, xen, s0o, s1o, s1v} <= 8'hdf;
    wr(`PBM_OFS_FUNC, 8'h7f);
    w(2);
    `CHK(pad_out_o[6:0], 7'h0b)
    `CHK(pad_oe_o, 8'h5f)
    @(posedge ref_clk_i);
    {pwm0, xen, tx} <= 3'h1;
    w(2);
    `CHK(pad_out_o[6:0], 7'h42)
    wr(`PBM_OFS_DIR, 8'h00);
    w(2);
    `CHK(pad_oe_o, 8'h50)
    $display("test functions done");
    wr(`PBM_OFS_PULL, 8'h00);
    wr(`PBM_OFS_ANA, 8'hff);
    rd(`PBM_OFS_ANA, 8'h0f);
    wr(`PBM_OFS_DIR, 8'h1b);
    wr(`PBM_OFS_OUT, 8'he4);
    wr(`PBM_OFS_PULL, 8'hff);
    w(2);
    `CHK(ana_line_sel_o, 16'hc963)
    `CHK(ana_connect_o, 8'hff)
    `CHK(pad_oe_o | pad_pullup_o | pad_in_enable_o, 8'h00)
    `CHK({async_rx_o, sync_line_in_o}, 3'b111)
    wr(`PBM_OFS_ANA, 8'h04);
    w(2);
    `CHK({ana_line_sel_o, ana_connect_o, pad_in_enable_o}, 32'h0900_30cf)
    $display("test analog done");
    @(posedge ref_clk_i);
    rst_b_i <= 0;
    w(1);
    `CHK({ana_connect_o, async_rx_o, sync_line_in_o}, 11'h007)
    @(posedge ref_clk_i);
    rst_b_i <= 1;
    rd(`PBM_OFS_FUNC, 8'h00);
    w(2);
    `CHK(pad_in_enable_o, 8'hff)
    $display("test second reset done");
    end_sim;
  end
endmodule // port_b_pin_function_mux_tb
